// ### src/spsa_pkg.sv
/*
 * Constants shared by the PCI segment arbiter and configuration-select block.
 * Assumes one 25 MHz system clock with a synchronous, active-low reset.
 */
`default_nettype none

package spsa_pkg;

	// ----------------------------------------
	// Segment shape
	// ----------------------------------------
	localparam int LNS_DATA_W = 32;
	localparam int LNS_CLK_MHZ = 33;
	localparam int WS_DATA_W = 64;
	localparam int WS_CLK_MHZ = 66;
	localparam int LINK_W = 16;
	localparam int HOST_ADDR_W = 36;

	// ----------------------------------------
	// Master counts and embedded legacy device count
	// ----------------------------------------
	localparam int LNS_MASTERS = 7;
	localparam int WS1_MASTERS = 3;
	localparam int WS2_MASTERS = 4;
	localparam int LNS_EMBEDDED = 5;

	// ----------------------------------------
	// Configuration select bit numbers
	// ----------------------------------------
	localparam logic [4:0] IDSEL_BASE = 5'h10;
	localparam logic [4:0] IDSEL_VIDEO = 5'h12;
	localparam logic [4:0] IDSEL_NIC1 = 5'h13;
	localparam logic [4:0] IDSEL_NIC2 = 5'h14;
	localparam logic [4:0] IDSEL_SLOT3 = 5'h18;
	localparam logic [4:0] IDSEL_SLOT4 = 5'h19;
	localparam logic [4:0] IDSEL_SOUTH = 5'h1F;
	localparam logic [4:0] IDSEL_SLOT1 = 5'h18;
	localparam logic [4:0] IDSEL_SLOT2 = 5'h19;
	localparam logic [4:0] IDSEL_SCSI = 5'h14;
	localparam logic [4:0] IDSEL_SLOT5 = 5'h18;
	localparam logic [4:0] IDSEL_SLOT6 = 5'h19;

	// ----------------------------------------
	// Decode defaults
	// ----------------------------------------
	localparam logic [35:0] MEM_TOP_RST = 36'h1_8000_0000;
	localparam logic [3:0] WS_TGT_WIN_RST = 4'hF;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] idsel_onehot(input logic [4:0] bitno);
		logic [4:0] ofs;
		ofs = bitno - IDSEL_BASE;
		return 16'h0001 << ofs;
	endfunction

	function automatic logic [4:0] lns_idsel_bit(input logic [2:0] dev);
		case (dev)
			3'h0: return IDSEL_VIDEO;
			3'h1: return IDSEL_NIC1;
			3'h2: return IDSEL_NIC2;
			3'h3: return IDSEL_SLOT3;
			3'h4: return IDSEL_SLOT4;
			default: return IDSEL_SOUTH;
		endcase
	endfunction

	function automatic logic [4:0] ws2_idsel_bit(input logic [1:0] dev);
		case (dev)
			2'h0: return IDSEL_SCSI;
			2'h1: return IDSEL_SLOT5;
			default: return IDSEL_SLOT6;
		endcase
	endfunction

endpackage

`default_nettype wire

// ### src/spsa_lru_arb.sv
/*
 * Least-recently-used request/grant arbiter for one PCI segment.
 * Assumes active-high requests and a bus-idle level from the segment.
 */
`default_nettype none

module spsa_lru_arb #(
	parameter int N = 3
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Requests and bus state
	input wire logic [N-1:0] i_req,
	input wire logic i_bus_idle,
	// Grants
	output logic [N-1:0] o_gnt,
	output logic [N-1:0] o_gnt_n
);

	// ----------------------------------------
	// Age matrix: row i bit j set means i older than j
	// ----------------------------------------
	function automatic logic [N*N-1:0] pri_init();
		logic [N*N-1:0] m;
		m = '0;
		for (int i = 0; i < N; i++)
			for (int j = 0; j < N; j++)
				m[i*N+j] = (i <= j);
		return m;
	endfunction

	logic [N*N-1:0] pri_q;
	logic [N*N-1:0] pri_d;
	logic [N-1:0] gnt_q;
	logic [N-1:0] gnt_n_q;
	logic [N-1:0] win;
	wire logic released = ((gnt_q & i_req) == '0);
	wire logic move = i_bus_idle && released;
	wire logic [N-1:0] gnt_d = move ? win : gnt_q;

	// Oldest waiting requester wins
	for (genvar g = 0; g < N; g++)
	begin : g_win
		assign win[g] = i_req[g] && (&(~i_req | pri_q[g*N +: N]));
	end

	always_comb
	begin
		pri_d = pri_q;
		if (move && (|win))
		begin
			for (int i = 0; i < N; i++)
				for (int j = 0; j < N; j++)
					if (i != j)
					begin
						if (win[i])
							pri_d[i*N+j] = 1'b0;
						if (win[j])
							pri_d[i*N+j] = 1'b1;
					end
		end
	end

	// Grant moves only when idle and owner released
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			pri_q <= pri_init();
			gnt_q <= '0;
			gnt_n_q <= '1;
		end
		else
		begin
			pri_q <= pri_d;
			gnt_q <= gnt_d;
			gnt_n_q <= ~gnt_d;
		end
	end

	assign o_gnt = gnt_q;
	assign o_gnt_n = gnt_n_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_grant_onehot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$onehot0(gnt_q) && (gnt_n_q == ~gnt_q))
		else $error("More than one grant or grant pair mismatch");

	chk_grant_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		($past(gnt_q) != '0 && $past(i_req & gnt_q) != '0) |-> $stable(gnt_q))
		else $error("Grant moved while owner still requesting");

	for (genvar k = 0; k < N; k++)
	begin : g_chk
		chk_lru_pick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
			$rose(gnt_q[k]) |-> $past(i_req[k] && (&(~i_req | pri_q[k*N +: N]))))
			else $error("Grant given to a requester that was not least recent");

		chk_lru_demote: assert property (@(posedge i_clk) disable iff (!i_rst_n)
			$rose(gnt_q[k]) |-> (pri_q[k*N +: N] == N'(1 << k)))
			else $error("New owner not made most recent");
	end

endmodule

`default_nettype wire

// ### src/spsa_top.sv
/*
 * PCI segment plumbing: arbitration, configuration select, device disables,
 * wide segment speed, host decode, inbound acceptance and inter-bridge link.
 * Assumes all pins synchronous to the 25 MHz clock.
 */
// How it works
// - Wide segment arbiters grant the requester served longest ago.
// - Legacy arbiter serves host bridge plus six external request/grant pairs.
// - Host bridge is arbitration and configuration source of the legacy segment.
// - Each device select is one upper address bit, one device at a time.
// - Legacy selects: video 18, nics 19 and 20, slots 24, 25, south 31.
// - Wide one slots 24 and 25; wide two scsi 20, slot five 24, slot six 25.
// - Legacy segment 32 bits at 33 MHz; wide segments 64 bits at 66.
// - Any slow card drops its whole wide segment to the low clock.
// - Each embedded legacy device except south bridge has a disable output.
// - I/O bridge is initiator and target on both wide segments.
// - Host requests steer to memory queue or outbound queue by address.
// - Link uses two one-way 16-bit paths, each with parity.
// - Host bridge accepts inbound requests from link and legacy segment.
`default_nettype none

module spsa_top
	import spsa_pkg::*;
#(
	parameter logic [35:0] MEM_TOP = MEM_TOP_RST,
	parameter logic [3:0] WS_TGT_WIN = WS_TGT_WIN_RST
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Legacy segment arbitration
	input wire logic I_HOST_BUS_REQ,
	input wire logic I_VIDEO_BUS_REQUEST_N,
	input wire logic I_NIC1_BUS_REQUEST_N,
	input wire logic I_NIC2_BUS_REQUEST_N,
	input wire logic I_SLOT3_BUS_REQUEST_N,
	input wire logic I_SLOT4_BUS_REQUEST_N,
	input wire logic I_SOUTHBRIDGE_BUS_REQUEST_N,
	input wire logic I_LNS_BUS_IDLE,
	output logic O_HOST_BUS_GNT,
	output logic O_VIDEO_BUS_GRANT_N,
	output logic O_NIC1_BUS_GRANT_N,
	output logic O_NIC2_BUS_GRANT_N,
	output logic O_SLOT3_BUS_GRANT_N,
	output logic O_SLOT4_BUS_GRANT_N,
	output logic O_SOUTHBRIDGE_BUS_GRANT_N,
	// Wide segment arbitration
	input wire logic I_WS1_BRIDGE_REQ,
	input wire logic [1:0] I_WS1_BUS_REQUEST_N,
	input wire logic I_WS1_BUS_IDLE,
	output logic O_WS1_BRIDGE_GNT,
	output logic [1:0] O_WS1_BUS_GRANT_N,
	input wire logic I_WS2_BRIDGE_REQ,
	input wire logic [2:0] I_WS2_BUS_REQUEST_N,
	input wire logic I_WS2_BUS_IDLE,
	output logic O_WS2_BRIDGE_GNT,
	output logic [2:0] O_WS2_BUS_GRANT_N,
	// Configuration select
	input wire logic I_LNS_CFG_STB,
	input wire logic [2:0] I_LNS_CFG_DEV,
	input wire logic I_WS1_CFG_STB,
	input wire logic I_WS1_CFG_DEV,
	input wire logic I_WS2_CFG_STB,
	input wire logic [1:0] I_WS2_CFG_DEV,
	output logic [15:0] O_LNS_IDSEL,
	output logic [15:0] O_WS1_IDSEL,
	output logic [15:0] O_WS2_IDSEL,
	// Device disables and segment speed
	input wire logic [LNS_EMBEDDED-1:0] I_DEV_DISABLE,
	output logic [LNS_EMBEDDED-1:0] O_DEV_DISABLE,
	input wire logic [1:0] I_WS1_SLOT_PRESENT,
	input wire logic [1:0] I_WS1_SLOT_M66,
	input wire logic [1:0] I_WS2_SLOT_PRESENT,
	input wire logic [1:0] I_WS2_SLOT_M66,
	output logic O_LNS_M66EN,
	output logic O_WS1_M66EN,
	output logic O_WS2_M66EN,
	// Wide segment target claim
	input wire logic I_WS1_ADDR_VALID,
	input wire logic [31:0] I_WS1_ADDR,
	input wire logic I_WS2_ADDR_VALID,
	input wire logic [31:0] I_WS2_ADDR,
	output logic O_WS1_TGT_CLAIM,
	output logic O_WS2_TGT_CLAIM,
	// Host request decode
	input wire logic I_HOST_REQ_VALID,
	input wire logic [HOST_ADDR_W-1:0] I_HOST_ADDR,
	output logic O_MEM_Q_PUSH,
	output logic O_OUT_Q_PUSH,
	// Inbound requests
	input wire logic I_INB_LINK_VALID,
	input wire logic I_INB_LEGACY_VALID,
	output logic O_INB_LINK_ACCEPT,
	output logic O_INB_LEGACY_ACCEPT,
	// Inter-bridge link
	input wire logic I_LINK_TX_VALID,
	input wire logic [LINK_W-1:0] I_LINK_TX_DATA,
	output logic O_LINK_TX_VALID,
	output logic [LINK_W-1:0] O_LINK_TX_DATA,
	output logic O_LINK_TX_PAR,
	input wire logic I_LINK_RX_VALID,
	input wire logic [LINK_W-1:0] I_LINK_RX_DATA,
	input wire logic I_LINK_RX_PAR,
	output logic O_LINK_RX_VALID,
	output logic [LINK_W-1:0] O_LINK_RX_DATA,
	output logic O_LINK_RX_PAR_ERR
);

	// ----------------------------------------
	// Arbiters
	// ----------------------------------------
	logic [LNS_MASTERS-1:0] lns_gnt;
	logic [LNS_MASTERS-1:0] lns_gnt_n;
	logic [WS1_MASTERS-1:0] ws1_gnt;
	logic [WS1_MASTERS-1:0] ws1_gnt_n;
	logic [WS2_MASTERS-1:0] ws2_gnt;
	logic [WS2_MASTERS-1:0] ws2_gnt_n;

	// Host bridge is master 0 of its own segment
	wire logic [LNS_MASTERS-1:0] lns_req = {~I_SOUTHBRIDGE_BUS_REQUEST_N,
		~I_SLOT4_BUS_REQUEST_N, ~I_SLOT3_BUS_REQUEST_N, ~I_NIC2_BUS_REQUEST_N,
		~I_NIC1_BUS_REQUEST_N, ~I_VIDEO_BUS_REQUEST_N, I_HOST_BUS_REQ};
	// I/O bridge is master 0 of each wide segment
	wire logic [WS1_MASTERS-1:0] ws1_req = {~I_WS1_BUS_REQUEST_N, I_WS1_BRIDGE_REQ};
	wire logic [WS2_MASTERS-1:0] ws2_req = {~I_WS2_BUS_REQUEST_N, I_WS2_BRIDGE_REQ};

	// Masters start only on grant, so idle plus release is a safe handover
	spsa_lru_arb #(.N(LNS_MASTERS)) u_lns_arb (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_req(lns_req),
		.i_bus_idle(I_LNS_BUS_IDLE),
		.o_gnt(lns_gnt),
		.o_gnt_n(lns_gnt_n)
	);

	spsa_lru_arb #(.N(WS1_MASTERS)) u_ws1_arb (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_req(ws1_req),
		.i_bus_idle(I_WS1_BUS_IDLE),
		.o_gnt(ws1_gnt),
		.o_gnt_n(ws1_gnt_n)
	);

	spsa_lru_arb #(.N(WS2_MASTERS)) u_ws2_arb (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_req(ws2_req),
		.i_bus_idle(I_WS2_BUS_IDLE),
		.o_gnt(ws2_gnt),
		.o_gnt_n(ws2_gnt_n)
	);

	assign O_HOST_BUS_GNT = lns_gnt[0];
	assign O_VIDEO_BUS_GRANT_N = lns_gnt_n[1];
	assign O_NIC1_BUS_GRANT_N = lns_gnt_n[2];
	assign O_NIC2_BUS_GRANT_N = lns_gnt_n[3];
	assign O_SLOT3_BUS_GRANT_N = lns_gnt_n[4];
	assign O_SLOT4_BUS_GRANT_N = lns_gnt_n[5];
	assign O_SOUTHBRIDGE_BUS_GRANT_N = lns_gnt_n[6];
	assign O_WS1_BRIDGE_GNT = ws1_gnt[0];
	assign O_WS1_BUS_GRANT_N = ws1_gnt_n[WS1_MASTERS-1:1];
	assign O_WS2_BRIDGE_GNT = ws2_gnt[0];
	assign O_WS2_BUS_GRANT_N = ws2_gnt_n[WS2_MASTERS-1:1];

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// One select bit per device, only during a configuration strobe
	wire logic [15:0] lns_idsel_d = I_LNS_CFG_STB ?
		idsel_onehot(lns_idsel_bit(I_LNS_CFG_DEV)) : 16'h0000;
	wire logic [15:0] ws1_idsel_d = !I_WS1_CFG_STB ? 16'h0000 :
		idsel_onehot(I_WS1_CFG_DEV ? IDSEL_SLOT2 : IDSEL_SLOT1);
	wire logic [15:0] ws2_idsel_d = I_WS2_CFG_STB ?
		idsel_onehot(ws2_idsel_bit(I_WS2_CFG_DEV)) : 16'h0000;
	// Slow card anywhere pulls the whole segment down
	wire logic ws1_fast = &(~I_WS1_SLOT_PRESENT | I_WS1_SLOT_M66);
	wire logic ws2_fast = &(~I_WS2_SLOT_PRESENT | I_WS2_SLOT_M66);
	wire logic ws1_hit = I_WS1_ADDR_VALID && (I_WS1_ADDR[31:28] == WS_TGT_WIN);
	wire logic ws2_hit = I_WS2_ADDR_VALID && (I_WS2_ADDR[31:28] == WS_TGT_WIN);
	wire logic host_mem = I_HOST_ADDR < MEM_TOP;
	// Link wins when both inbound sources present; legacy holds its request
	wire logic legacy_take = I_INB_LEGACY_VALID && !I_INB_LINK_VALID;
	wire logic rx_par_bad = I_LINK_RX_VALID && ((^I_LINK_RX_DATA) != I_LINK_RX_PAR);

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_N)
		begin
			O_LNS_IDSEL <= 16'h0000;
			O_WS1_IDSEL <= 16'h0000;
			O_WS2_IDSEL <= 16'h0000;
			O_DEV_DISABLE <= '0;
			O_LNS_M66EN <= 1'b0;
			O_WS1_M66EN <= 1'b0;
			O_WS2_M66EN <= 1'b0;
			O_WS1_TGT_CLAIM <= 1'b0;
			O_WS2_TGT_CLAIM <= 1'b0;
			O_MEM_Q_PUSH <= 1'b0;
			O_OUT_Q_PUSH <= 1'b0;
			O_INB_LINK_ACCEPT <= 1'b0;
			O_INB_LEGACY_ACCEPT <= 1'b0;
			O_LINK_TX_VALID <= 1'b0;
			O_LINK_TX_DATA <= '0;
			O_LINK_TX_PAR <= 1'b0;
			O_LINK_RX_VALID <= 1'b0;
			O_LINK_RX_DATA <= '0;
			O_LINK_RX_PAR_ERR <= 1'b0;
		end
		else
		begin
			O_LNS_IDSEL <= lns_idsel_d;
			O_WS1_IDSEL <= ws1_idsel_d;
			O_WS2_IDSEL <= ws2_idsel_d;
			O_DEV_DISABLE <= I_DEV_DISABLE;
			O_LNS_M66EN <= 1'b0;
			O_WS1_M66EN <= ws1_fast;
			O_WS2_M66EN <= ws2_fast;
			O_WS1_TGT_CLAIM <= ws1_hit;
			O_WS2_TGT_CLAIM <= ws2_hit;
			O_MEM_Q_PUSH <= I_HOST_REQ_VALID && host_mem;
			O_OUT_Q_PUSH <= I_HOST_REQ_VALID && !host_mem;
			O_INB_LINK_ACCEPT <= I_INB_LINK_VALID;
			O_INB_LEGACY_ACCEPT <= legacy_take;
			O_LINK_TX_VALID <= I_LINK_TX_VALID;
			O_LINK_TX_DATA <= I_LINK_TX_DATA;
			O_LINK_TX_PAR <= ^I_LINK_TX_DATA;
			O_LINK_RX_VALID <= I_LINK_RX_VALID;
			O_LINK_RX_DATA <= I_LINK_RX_DATA;
			O_LINK_RX_PAR_ERR <= rx_par_bad;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_idsel_onehot: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$onehot0(O_LNS_IDSEL) && $onehot0(O_WS1_IDSEL) && $onehot0(O_WS2_IDSEL))
		else $error("Configuration select drives more than one device");

	chk_idsel_legacy: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(I_LNS_CFG_STB && I_LNS_CFG_DEV == 3'h0) |=> (O_LNS_IDSEL == 16'h0004))
		else $error("Video select bit wrong");

	chk_idsel_south: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(I_LNS_CFG_STB && I_LNS_CFG_DEV == 3'h5) |=> (O_LNS_IDSEL == 16'h8000))
		else $error("South bridge select bit wrong");

	chk_idsel_wide: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(I_WS2_CFG_STB && I_WS2_CFG_DEV == 2'h0) |=> (O_WS2_IDSEL == 16'h0010))
		else $error("Storage controller select bit wrong");

	chk_speed_drop: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(|(I_WS2_SLOT_PRESENT & ~I_WS2_SLOT_M66)) |=> !O_WS2_M66EN)
		else $error("Wide segment kept fast with a slow card present");

	chk_disable_follow: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		##1 (O_DEV_DISABLE == $past(I_DEV_DISABLE)))
		else $error("Device disable does not follow its request");

	chk_decode_split: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_HOST_REQ_VALID |=> (O_MEM_Q_PUSH ^ O_OUT_Q_PUSH))
		else $error("Host request not steered to exactly one queue");

	chk_link_parity: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		O_LINK_TX_VALID |-> (O_LINK_TX_PAR == ^O_LINK_TX_DATA))
		else $error("Outgoing link parity wrong");

	chk_inbound_take: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(I_INB_LEGACY_VALID && I_INB_LINK_VALID) ##1 !I_INB_LINK_VALID
		|-> ##1 O_INB_LEGACY_ACCEPT)
		else $error("Waiting legacy inbound request not accepted");

endmodule

`default_nettype wire

// ### tb/spsa_master_model.sv
/*
 * Behavioural PCI masters of one segment, with request, grant and bus idle.
 * Assumes the bench raises a want bit per master; a rise asks for one transfer.
 */
`default_nettype none

module spsa_master_model #(
	parameter int N = 2,
	parameter int HOLD = 3
) (
	// Clock and stimulus
	input wire logic i_clk,
	input wire logic [N-1:0] i_want,
	// Arbitration
	input wire logic [N-1:0] i_gnt_n,
	output logic [N-1:0] o_req_n,
	// Bus state
	output logic o_bus_idle,
	output logic [7:0] o_done
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [N-1:0] prev;
	logic busy;
	int own;
	int cnt;

	initial
	begin
		o_req_n = '1;
		o_bus_idle = 1'b1;
		o_done = 8'h00;
		prev = '0;
		busy = 1'b0;
		own = 0;
		cnt = 0;
	end

	// ----------------------------------------
	// Request, wait for grant, own bus, release
	// ----------------------------------------
	always @(posedge i_clk)
	begin
		#2;
		if (busy)
		begin
			cnt--;
			if (cnt == 0)
			begin
				busy = 1'b0;
				o_req_n[own] = 1'b1;
				o_bus_idle = 1'b1;
				o_done = o_done + 8'h01;
			end
		end
		else
		begin
			for (int k = 0; k < N; k++)
			begin
				if (!busy && !o_req_n[k] && !i_gnt_n[k])
				begin
					busy = 1'b1;
					own = k;
					cnt = HOLD;
					o_bus_idle = 1'b0;
				end
			end
		end
		for (int k = 0; k < N; k++)
		begin
			if (i_want[k] && !prev[k])
				o_req_n[k] = 1'b0;
		end
		prev = i_want;
	end
endmodule

`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench for spsa_top, one task per scenario.
 * Assumes master models drive the segment requests and bus idle.
 */
`default_nettype none

`define CHK(nm, e, g) \
	begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module tb_top
	import spsa_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	logic clk, rst_n, host_req, host_g, b1req, b2req, w1g, w2g, lidle, w1idle, w2idle;
	logic [5:0] want_l, lreq_n;
	wire [5:0] lgnt_n;
	logic [1:0] want_1, w1req_n, w1gnt_n, w2dev, p1, m1, p2, m2;
	logic [2:0] want_2, w2req_n, w2gnt_n, ldev;
	logic [7:0] dn0, dn1, dn2;
	logic lcs, w1cs, w2cs, w1dev, lm66, w1m66, w2m66, a1v, a2v, cl1, cl2;
	logic [15:0] lid, w1id, w2id, td, otd, rd, ord;
	logic [4:0] dis_i, dis_o;
	logic [31:0] a1, a2;
	logic [35:0] ha;
	logic hv, mq, oq, ilv, igv, ila, iga, tv, otv, otp, rv, rp, orv, ope;

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	spsa_master_model #(.N(6), .HOLD(3)) i_lns (.i_clk(clk), .i_want(want_l),
		.i_gnt_n(lgnt_n), .o_req_n(lreq_n), .o_bus_idle(lidle), .o_done(dn0));
	spsa_master_model #(.N(2), .HOLD(3)) i_ws1 (.i_clk(clk), .i_want(want_1),
		.i_gnt_n(w1gnt_n), .o_req_n(w1req_n), .o_bus_idle(w1idle), .o_done(dn1));
	spsa_master_model #(.N(3), .HOLD(6)) i_ws2 (.i_clk(clk), .i_want(want_2),
		.i_gnt_n(w2gnt_n), .o_req_n(w2req_n), .o_bus_idle(w2idle), .o_done(dn2));

	spsa_top i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_HOST_BUS_REQ(host_req),
		.I_VIDEO_BUS_REQUEST_N(lreq_n[0]), .I_NIC1_BUS_REQUEST_N(lreq_n[1]),
		.I_NIC2_BUS_REQUEST_N(lreq_n[2]), .I_SLOT3_BUS_REQUEST_N(lreq_n[3]),
		.I_SLOT4_BUS_REQUEST_N(lreq_n[4]), .I_SOUTHBRIDGE_BUS_REQUEST_N(lreq_n[5]),
		.I_LNS_BUS_IDLE(lidle), .O_HOST_BUS_GNT(host_g),
		.O_VIDEO_BUS_GRANT_N(lgnt_n[0]), .O_NIC1_BUS_GRANT_N(lgnt_n[1]),
		.O_NIC2_BUS_GRANT_N(lgnt_n[2]), .O_SLOT3_BUS_GRANT_N(lgnt_n[3]),
		.O_SLOT4_BUS_GRANT_N(lgnt_n[4]), .O_SOUTHBRIDGE_BUS_GRANT_N(lgnt_n[5]),
		.I_WS1_BRIDGE_REQ(b1req), .I_WS1_BUS_REQUEST_N(w1req_n), .I_WS1_BUS_IDLE(w1idle),
		.O_WS1_BRIDGE_GNT(w1g), .O_WS1_BUS_GRANT_N(w1gnt_n), .I_WS2_BRIDGE_REQ(b2req),
		.I_WS2_BUS_REQUEST_N(w2req_n), .I_WS2_BUS_IDLE(w2idle), .O_WS2_BRIDGE_GNT(w2g),
		.O_WS2_BUS_GRANT_N(w2gnt_n), .I_LNS_CFG_STB(lcs), .I_LNS_CFG_DEV(ldev),
		.I_WS1_CFG_STB(w1cs), .I_WS1_CFG_DEV(w1dev), .I_WS2_CFG_STB(w2cs),
		.I_WS2_CFG_DEV(w2dev), .O_LNS_IDSEL(lid), .O_WS1_IDSEL(w1id), .O_WS2_IDSEL(w2id),
		.I_DEV_DISABLE(dis_i), .O_DEV_DISABLE(dis_o), .I_WS1_SLOT_PRESENT(p1),
		.I_WS1_SLOT_M66(m1), .I_WS2_SLOT_PRESENT(p2), .I_WS2_SLOT_M66(m2),
		.O_LNS_M66EN(lm66), .O_WS1_M66EN(w1m66), .O_WS2_M66EN(w2m66),
		.I_WS1_ADDR_VALID(a1v), .I_WS1_ADDR(a1), .I_WS2_ADDR_VALID(a2v), .I_WS2_ADDR(a2),
		.O_WS1_TGT_CLAIM(cl1), .O_WS2_TGT_CLAIM(cl2), .I_HOST_REQ_VALID(hv),
		.I_HOST_ADDR(ha), .O_MEM_Q_PUSH(mq), .O_OUT_Q_PUSH(oq), .I_INB_LINK_VALID(ilv),
		.I_INB_LEGACY_VALID(igv), .O_INB_LINK_ACCEPT(ila), .O_INB_LEGACY_ACCEPT(iga),
		.I_LINK_TX_VALID(tv), .I_LINK_TX_DATA(td), .O_LINK_TX_VALID(otv),
		.O_LINK_TX_DATA(otd), .O_LINK_TX_PAR(otp), .I_LINK_RX_VALID(rv),
		.I_LINK_RX_DATA(rd), .I_LINK_RX_PAR(rp), .O_LINK_RX_VALID(orv),
		.O_LINK_RX_DATA(ord), .O_LINK_RX_PAR_ERR(ope));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [6:0] gnt_of(input int s);
		if (s == 0)
			return {~lgnt_n, host_g};
		if (s == 1)
			return {4'h0, ~w1gnt_n, w1g};
		return {3'h0, ~w2gnt_n, w2g};
	endfunction

	function automatic logic [7:0] done_of(input int s);
		return (s == 0) ? dn0 : (s == 1) ? dn1 : dn2;
	endfunction

	task automatic setw(input int s, input int k, input logic v);
		if (s == 0)
			want_l[k-1] = v;
		else if (s == 1)
			want_1[k-1] = v;
		else
			want_2[k-1] = v;
	endtask

	task automatic wait_done(input int s, input logic [7:0] d);
		int n;
		n = 0;
		while (done_of(s) !== d && n < 60)
		begin
			cyc(1);
			n++;
		end
		`CHK("transfers done", d, done_of(s))
	endtask

	task automatic serve(input int s, input int k);
		logic [7:0] d;
		d = done_of(s);
		setw(s, k, 1'b1);
		wait_done(s, d + 8'h01);
		setw(s, k, 1'b0);
		cyc(1);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_lru(input int s, input int a, input int b);
		logic [7:0] d;
		int n;
		serve(s, a);
		serve(s, b);
		d = done_of(s);
		setw(s, a, 1'b1);
		setw(s, b, 1'b1);
		n = 0;
		while (gnt_of(s) === 7'h00 && n < 20)
		begin
			cyc(1);
			n++;
		end
		`CHK("oldest wins", 7'h01 << a, gnt_of(s))
		cyc(2);
		`CHK("grant held while busy", 7'h01 << a, gnt_of(s))
		wait_done(s, d + 8'h02);
		setw(s, a, 1'b0);
		setw(s, b, 1'b0);
		cyc(1);
		$display("test lru seg %0d pair %0d %0d done", s, a, b);
	endtask

	task automatic t_own();
		host_req = 1'b1;
		b1req = 1'b1;
		b2req = 1'b1;
		cyc(2);
		`CHK("host grant", 1'b1, host_g)
		`CHK("bridge one grant", 1'b1, w1g)
		`CHK("bridge two grant", 1'b1, w2g)
		host_req = 1'b0;
		b1req = 1'b0;
		b2req = 1'b0;
		cyc(2);
		`CHK("grants free", 7'h00, gnt_of(0) | gnt_of(1) | gnt_of(2))
		$display("test own done");
	endtask

	task automatic t_idsel();
		int lb[6] = '{18, 19, 20, 24, 25, 31};
		lcs = 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			ldev = 3'(k);
			cyc(1);
			`CHK("legacy select", 16'h0001 << (lb[k] - 16), lid)
		end
		lcs = 1'b0;
		w1cs = 1'b1;
		w2cs = 1'b1;
		w1dev = 1'b0;
		w2dev = 2'h0;
		cyc(1);
		`CHK("wide one select", 16'h0100, w1id)
		`CHK("wide two select", 16'h0010, w2id)
		w1dev = 1'b1;
		w2dev = 2'h1;
		cyc(1);
		`CHK("wide one select", 16'h0200, w1id)
		`CHK("wide two select", 16'h0100, w2id)
		w2dev = 2'h2;
		cyc(1);
		`CHK("wide two slot six select", 16'h0200, w2id)
		w1cs = 1'b0;
		w2cs = 1'b0;
		cyc(1);
		`CHK("no select", 16'h0000, lid | w1id | w2id)
		$display("test idsel done");
	endtask

	task automatic t_misc();
		logic [1:0] pv[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
		logic [1:0] mv[4] = '{2'h3, 2'h2, 2'h2, 2'h0};
		logic [15:0] wv[3] = '{16'h0001, 16'hA5C3, 16'hFFFE};
		for (int k = 0; k < 5; k++)
		begin
			dis_i = 5'h01 << k;
			cyc(1);
			`CHK("disable", 5'h01 << k, dis_o)
		end
		for (int k = 0; k < 4; k++)
		begin
			p1 = pv[k];
			m1 = mv[k];
			p2 = pv[3-k];
			m2 = mv[3-k];
			cyc(1);
			`CHK("wide one fast", ~|(pv[k] & ~mv[k]), w1m66)
			`CHK("wide two fast", ~|(pv[3-k] & ~mv[3-k]), w2m66)
			`CHK("legacy fast", 1'b0, lm66)
		end
		tv = 1'b1;
		rv = 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			td = wv[k];
			rd = wv[2-k];
			rp = (^wv[2-k]) ^ k[0];
			cyc(1);
			`CHK("tx data", wv[k], otd)
			`CHK("tx parity", ^wv[k], otp)
			`CHK("rx data", wv[2-k], ord)
			`CHK("rx parity error", k[0], ope)
			`CHK("link valids", 2'h3, {otv, orv})
		end
		tv = 1'b0;
		rv = 1'b0;
		cyc(1);
		`CHK("link valids idle", 2'h0, {otv, orv})
		$display("test disable speed link done");
	endtask

	task automatic t_flow();
		hv = 1'b1;
		ha = 36'h0;
		cyc(1);
		`CHK("memory push", 2'h2, {mq, oq})
		ha = MEM_TOP_RST - 36'h1;
		cyc(1);
		`CHK("memory push top", 2'h2, {mq, oq})
		ha = MEM_TOP_RST;
		cyc(1);
		`CHK("outbound push", 2'h1, {mq, oq})
		hv = 1'b0;
		ilv = 1'b1;
		igv = 1'b1;
		cyc(1);
		`CHK("push ends", 2'h0, {mq, oq})
		`CHK("link inbound first", 2'h2, {ila, iga})
		ilv = 1'b0;
		a1v = 1'b1;
		a2v = 1'b1;
		cyc(1);
		`CHK("legacy inbound", 2'h1, {ila, iga})
		`CHK("target claims", 2'h2, {cl1, cl2})
		a1 = 32'hE000_0000;
		a2 = 32'hF000_0004;
		cyc(1);
		`CHK("target claims swapped", 2'h1, {cl1, cl2})
		igv = 1'b0;
		a1v = 1'b0;
		a2v = 1'b0;
		$display("test decode inbound claim done");
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Monitor, timeout and main sequence
	// ----------------------------------------
	always @(negedge clk)
	begin
		if (rst_n)
		begin
			`CHK("one legacy grant", 1'b1, $onehot0(gnt_of(0)))
			`CHK("one wide grant", 1'b1, $onehot0(gnt_of(1)) & $onehot0(gnt_of(2)))
		end
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			finish_test();
		end
	end

	initial
	begin
		{rst_n, host_req, b1req, b2req, lcs, w1cs, w2cs, w1dev, a1v, a2v} = '0;
		{hv, ilv, igv, tv, rv, rp} = '0;
		{want_l, want_1, want_2, ldev, w2dev, dis_i, p1, m1, p2, m2} = '0;
		{td, rd, ha} = '0;
		a1 = 32'hF000_0010;
		a2 = 32'hE000_0000;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		cyc(1);
		`CHK("reset grants", 7'h00, gnt_of(0) | gnt_of(1) | gnt_of(2))
		t_own();
		t_lru(0, 1, 4);
		t_lru(0, 6, 3);
		t_lru(0, 5, 2);
		t_lru(1, 1, 2);
		t_lru(1, 2, 1);
		t_lru(2, 1, 3);
		t_lru(2, 3, 2);
		t_idsel();
		t_misc();
		t_flow();
		finish_test();
	end
endmodule

`default_nettype wire
